// >>> core/ecfm_pkg.sv
// Constants and types for the core frame mapper
package ecfm_pkg;
  localparam int unsigned CLK_HZ        = 125000000;
  localparam int unsigned FRAME_US      = 500;
  localparam int unsigned FRAME_BYTES   = 144;
  localparam int unsigned PAYLOAD_BYTES = 128;
  localparam int unsigned FILL_BYTES    = 16;
  localparam int unsigned FILL_PERIOD   = 9;
  localparam int unsigned SPARE_FIRST   = 9;
  localparam int unsigned SPARE_LAST    = 48;
  localparam int unsigned SPARE_BITS    = SPARE_LAST - SPARE_FIRST + 1;
  localparam int unsigned FRAME_CYCLES  = CLK_HZ / 1000000 * FRAME_US;
  localparam int unsigned FRAME_CNT_W   = 17;
  localparam int unsigned BYTE_CNT_W    = 8;
  localparam int unsigned DELAY_MAX_US  = 450;
  localparam int unsigned CLK_PPM_TOL   = 50;
  localparam logic [7:0]  FILL_VALUE    = 8'hff;
  localparam logic [BYTE_CNT_W-1:0] BYTE_LAST  = 8'h8f;
  localparam logic [BYTE_CNT_W-1:0] FILL_MOD   = 8'h09;
  localparam logic [BYTE_CNT_W-1:0] FILL_SLOT  = 8'h08;
  localparam logic [BYTE_CNT_W-1:0] BYTE_ZERO  = 8'h00;
  localparam int unsigned NUM_PAIRS     = 3;
  // Register map, word aligned byte addresses
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_STATUS    = 8'h04;
  localparam logic [7:0]  REG_FRAMES    = 8'h08;
  localparam int unsigned CTRL_ENABLE   = 0;
  localparam int unsigned CTRL_UNSTRUCT = 1;
  localparam int unsigned CTRL_FAIL     = 2;
  localparam logic [31:0] BAD_ADDR_DATA = 32'hdeadbeef;
  typedef enum logic [2:0] {
    ECFM_IDLE    = 3'b001,
    ECFM_PAYLOAD = 3'b010,
    ECFM_FILL    = 3'b100
  } ecfm_state_type;
endpackage

// >>> core/ecfm_frame_mapper.sv
// Core frame mapper: payload bytes plus fill into 144-byte, 500 us frames
//
// Decided for this implementation: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module ecfm_frame_mapper
  import ecfm_pkg::*;
(
  input  wire logic                 clk_i,            // 125 MHz clock
  input  wire logic                 rst_b_i,          // Async reset, active low
  input  wire logic [7:0]           avs_address_i,    // Byte address
  input  wire logic                 avs_read_i,       // Read request
  input  wire logic                 avs_write_i,      // Write request
  input  wire logic [31:0]          avs_writedata_i,  // Write data
  input  wire logic [3:0]           avs_byteenable_i, // Byte enables
  output logic      [31:0]          avs_readdata_o,   // Read data
  output logic                      avs_waitrequest_o,// Wait request
  input  wire logic [7:0]           app_data_i,       // Application byte
  input  wire logic                 app_valid_i,      // Application byte valid
  output logic                      app_ready_o,      // Buffer can take a byte
  output logic [7:0]                line_data_o,      // Core frame byte
  output logic                      line_valid_o,     // Core frame byte valid
  output logic                      line_sof_o,       // First byte of frame
  output logic                      line_fill_o,      // Byte is fill
  output logic [SPARE_BITS-1:0]     spare_overhead_bits_o, // Spare overhead bits
  input  wire logic                 line_ready_i,     // Transceiver takes byte
  input  wire logic [NUM_PAIRS-1:0] pair_active_i,    // Pair activation done (pin)
  input  wire logic [NUM_PAIRS-1:0] pair_id_ok_i,     // Pair identification ok (pin)
  input  wire logic                 line_loss_i,      // Line-side loss/FRAME_ALIGNMENT_LOSS (pin)
  input  wire logic                 loopback_req_i,   // Exchange side loopback request
  output logic                      loopback_o,       // Loopback to all transceivers
  output logic                      section_oper_o,   // Access section operational
  output logic                      line_loss_ind_o,  // Line-side loss indication
  output logic                      active_ind_o      // Remote/central active indication
);
  import ecfm_pkg::*;

  // Two-flop synchronisers for pin inputs
  localparam int unsigned SYNC_W = 2 * NUM_PAIRS + 2;
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {loopback_req_i, line_loss_i, pair_id_ok_i, pair_active_i};
      sync2_q <= sync1_q;
    end
  end
  logic [NUM_PAIRS-1:0] pair_act_s;
  logic [NUM_PAIRS-1:0] pair_id_s;
  logic                 loss_s;
  logic                 lb_req_s;
  assign pair_act_s = sync2_q[NUM_PAIRS-1:0];
  assign pair_id_s  = sync2_q[2*NUM_PAIRS-1:NUM_PAIRS];
  assign loss_s     = sync2_q[2*NUM_PAIRS];
  assign lb_req_s   = sync2_q[2*NUM_PAIRS+1];

  // Registers
  logic [2:0]  ctrl_q;
  logic [2:0]  ctrl_d;
  logic [15:0] frames_q;
  logic [15:0] frames_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        ack_q;
  logic        ack_d;
  logic        oper_q;
  logic        oper_d;
  logic        lb_q;
  logic        lb_d;
  logic        lossind_q;
  logic        lossind_d;
  logic        actind_q;
  logic        actind_d;

  // Two-entry input buffer
  logic [7:0] buf_mem [2];
  logic [1:0] buf_cnt_q;
  logic [1:0] buf_cnt_d;
  logic       buf_wp_q;
  logic       buf_wp_d;
  logic       buf_rp_q;
  logic       buf_rp_d;
  logic [7:0] buf_w0_d;
  logic [7:0] buf_w1_d;
  logic       buf_push;
  logic       buf_pop;
  logic       buf_valid;

  // Framer state
  ecfm_state_type            state_q;
  ecfm_state_type            state_d;
  logic [BYTE_CNT_W-1:0]     byte_q;
  logic [BYTE_CNT_W-1:0]     byte_d;
  logic [BYTE_CNT_W-1:0]     slot_q;
  logic [BYTE_CNT_W-1:0]     slot_d;
  logic [FRAME_CNT_W-1:0]    tick_q;
  logic [FRAME_CNT_W-1:0]    tick_d;
  logic [7:0]                odata_q;
  logic [7:0]                odata_d;
  logic                      ovalid_q;
  logic                      ovalid_d;
  logic                      osof_q;
  logic                      osof_d;
  logic                      ofill_q;
  logic                      ofill_d;
  logic                      bus_req;
  logic                      out_free;
  logic                      is_fill;

  assign bus_req   = (avs_read_i | avs_write_i) & ~ack_q;
  assign buf_valid = (buf_cnt_q != 2'd0);
  assign app_ready_o = (buf_cnt_q != 2'd2);
  assign buf_push  = app_valid_i & app_ready_o;
  assign out_free  = ~ovalid_q | line_ready_i;
  // Fixed fill position: last byte of every group of nine
  assign is_fill   = (slot_q == FILL_SLOT);

  always_comb begin
    buf_cnt_d = buf_cnt_q;
    buf_wp_d  = buf_wp_q;
    buf_rp_d  = buf_rp_q;
    buf_w0_d  = buf_mem[0];
    buf_w1_d  = buf_mem[1];
    if (buf_push) begin
      if (buf_wp_q) begin
        buf_w1_d = app_data_i;
      end else begin
        buf_w0_d = app_data_i;
      end
      buf_wp_d = ~buf_wp_q;
    end
    if (buf_pop) begin
      buf_rp_d = ~buf_rp_q;
    end
    buf_cnt_d = buf_cnt_q + {1'b0, buf_push} - {1'b0, buf_pop};
  end

  // Frame pacing and byte sequencing
  always_comb begin
    state_d  = state_q;
    byte_d   = byte_q;
    slot_d   = slot_q;
    tick_d   = tick_q;
    odata_d  = odata_q;
    ovalid_d = ovalid_q & ~line_ready_i;
    osof_d   = osof_q;
    ofill_d  = ofill_q;
    frames_d = frames_q;
    buf_pop  = 1'b0;
    if (ctrl_q[CTRL_ENABLE]) begin
      // Frame period of 500 us
      if (tick_q == FRAME_CNT_W'(FRAME_CYCLES - 1)) begin
        tick_d = '0;
      end else begin
        tick_d = tick_q + 1'b1;
      end
    end else begin
      tick_d = '0;
    end
    case (state_q)
      ECFM_IDLE: begin
        if (ctrl_q[CTRL_ENABLE] && tick_q == '0) begin
          state_d = ECFM_PAYLOAD;
          byte_d  = BYTE_ZERO;
          slot_d  = BYTE_ZERO;
        end
      end
      ECFM_PAYLOAD, ECFM_FILL: begin
        // Payload bytes taken opaque, no alignment search
        if (out_free && (is_fill || buf_valid)) begin
          ovalid_d = 1'b1;
          osof_d   = (byte_q == BYTE_ZERO);
          ofill_d  = is_fill;
          if (is_fill) begin
            odata_d = FILL_VALUE;
            state_d = ECFM_FILL;
          end else begin
            odata_d = buf_rp_q ? buf_mem[1] : buf_mem[0];
            buf_pop = 1'b1;
            state_d = ECFM_PAYLOAD;
          end
          slot_d = (slot_q == FILL_MOD - 1'b1) ? BYTE_ZERO : slot_q + 1'b1;
          if (byte_q == BYTE_LAST) begin
            byte_d   = BYTE_ZERO;
            frames_d = frames_q + 1'b1;
            state_d  = ECFM_IDLE;
          end else begin
            byte_d = byte_q + 1'b1;
          end
        end
        if (!ctrl_q[CTRL_ENABLE]) begin
          state_d = ECFM_IDLE;
        end
      end
      default: begin
        state_d = ECFM_IDLE;
      end
    endcase
  end

  // Maintenance: status from line side and the CTRL_FAIL bit, never from application framing
  always_comb begin
    oper_d    = (&pair_act_s) & (&pair_id_s) & ~loss_s & ~ctrl_q[CTRL_FAIL];
    lossind_d = loss_s;
    actind_d  = oper_d;
    lb_d      = lb_req_s;
  end

  // Avalon slave, one wait cycle then answer
  always_comb begin
    ctrl_d  = ctrl_q;
    rdata_d = rdata_q;
    ack_d   = bus_req;
    if (bus_req) begin
      if (avs_address_i == REG_CTRL) begin
        rdata_d = {29'h0, ctrl_q};
      end else if (avs_address_i == REG_STATUS) begin
        rdata_d = {22'h0, pair_id_s, pair_act_s, lb_q, lossind_q, oper_q,
                   ctrl_q[CTRL_UNSTRUCT]};
      end else if (avs_address_i == REG_FRAMES) begin
        rdata_d = {16'h0, frames_q};
      end else begin
        rdata_d = BAD_ADDR_DATA;
      end
    end
    // Write lands on the accept edge, where waitrequest is low
    if (avs_write_i && ack_q && avs_byteenable_i[0] && (avs_address_i == REG_CTRL)) begin
      ctrl_d = avs_writedata_i[2:0];
    end
  end
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;
  assign avs_readdata_o    = rdata_q;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_q    <= '0;
      frames_q  <= '0;
      rdata_q   <= '0;
      ack_q     <= 1'b0;
      oper_q    <= 1'b0;
      lb_q      <= 1'b0;
      lossind_q <= 1'b0;
      actind_q  <= 1'b0;
      buf_cnt_q <= '0;
      buf_wp_q  <= 1'b0;
      buf_rp_q  <= 1'b0;
      buf_mem[0] <= '0;
      buf_mem[1] <= '0;
      state_q   <= ECFM_IDLE;
      byte_q    <= '0;
      slot_q    <= '0;
      tick_q    <= '0;
      odata_q   <= '0;
      ovalid_q  <= 1'b0;
      osof_q    <= 1'b0;
      ofill_q   <= 1'b0;
    end else begin
      ctrl_q    <= ctrl_d;
      frames_q  <= frames_d;
      rdata_q   <= rdata_d;
      ack_q     <= ack_d;
      oper_q    <= oper_d;
      lb_q      <= lb_d;
      lossind_q <= lossind_d;
      actind_q  <= actind_d;
      buf_cnt_q <= buf_cnt_d;
      buf_wp_q  <= buf_wp_d;
      buf_rp_q  <= buf_rp_d;
      buf_mem[0] <= buf_w0_d;
      buf_mem[1] <= buf_w1_d;
      state_q   <= state_d;
      byte_q    <= byte_d;
      slot_q    <= slot_d;
      tick_q    <= tick_d;
      odata_q   <= odata_d;
      ovalid_q  <= ovalid_d;
      osof_q    <= osof_d;
      ofill_q   <= ofill_d;
    end
  end

  assign line_data_o           = odata_q;
  assign line_valid_o          = ovalid_q;
  assign line_sof_o            = osof_q;
  assign line_fill_o           = ofill_q;
  assign spare_overhead_bits_o = '1;
  assign loopback_o            = lb_q;
  assign section_oper_o        = oper_q;
  assign line_loss_ind_o       = lossind_q;
  assign active_ind_o          = actind_q;
endmodule
`default_nettype wire

// >>> tb/ecfm_frame_mapper_chk.sv
// Port-level checks on the core frame mapper
`timescale 1ns/1ps
`default_nettype none
module ecfm_frame_mapper_chk
  import ecfm_pkg::*;
(
  input wire logic                  clk_i,                 // Clock
  input wire logic                  rst_b_i,               // Reset, active low
  input wire logic                  avs_read_i,            // Read request
  input wire logic                  avs_write_i,           // Write request
  input wire logic                  avs_waitrequest_o,     // Wait request
  input wire logic [7:0]            line_data_o,           // Frame byte
  input wire logic                  line_valid_o,          // Byte valid
  input wire logic                  line_sof_o,            // First byte
  input wire logic                  line_fill_o,           // Fill marker
  input wire logic [SPARE_BITS-1:0] spare_overhead_bits_o, // Spare bits
  input wire logic                  line_ready_i,          // Byte taken
  input wire logic [NUM_PAIRS-1:0]  pair_active_i,         // Pairs active
  input wire logic                  line_loss_i,           // Line loss pin
  input wire logic                  loopback_req_i,        // Loopback request
  input wire logic                  loopback_o,            // Loopback
  input wire logic                  section_oper_o,        // Operational
  input wire logic                  line_loss_ind_o,       // Loss indication
  input wire logic                  active_ind_o           // Active indication
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence bus_req_rise;
    $rose(avs_read_i | avs_write_i);
  endsequence
  sequence one_wait;
    avs_waitrequest_o ##1 !avs_waitrequest_o;
  endsequence
  chk_bus_wait: assert property (bus_req_rise |-> one_wait)
    else $error("bus answer not after one wait cycle");
  chk_fill_ones: assert property (line_valid_o && line_fill_o |-> line_data_o == FILL_VALUE)
    else $error("fill byte not all ones");
  chk_spare_ones: assert property (&spare_overhead_bits_o)
    else $error("spare bits not all ones");
  chk_line_hold: assert property (line_valid_o && !line_ready_i |=>
    line_valid_o && $stable(line_data_o) && $stable(line_fill_o))
    else $error("line byte changed before taken");
  chk_sof_payload: assert property (line_valid_o && line_sof_o |-> !line_fill_o)
    else $error("frame starts on fill");
  chk_oper_drop: assert property ((!(&pair_active_i))[*4] |-> !section_oper_o)
    else $error("operational with pair inactive");
  chk_loop_on: assert property (loopback_req_i[*4] |-> loopback_o)
    else $error("loopback not applied");
  chk_loop_off: assert property ((!loopback_req_i)[*4] |-> !loopback_o)
    else $error("loopback without request");
  chk_loss_ind: assert property (line_loss_i[*4] |-> line_loss_ind_o && !section_oper_o)
    else $error("line loss not indicated");
  chk_ind_match: assert property (active_ind_o == section_oper_o)
    else $error("active indication differs");
endmodule
`default_nettype wire

// >>> tb/ecfm_line_model.sv
// Line transceiver sink that stalls and records one core frame
`timescale 1ns/1ps
`default_nettype none
module ecfm_line_model
  import ecfm_pkg::*;
(
  input  wire logic       clk_i,        // Clock
  input  wire logic       rst_b_i,      // Reset, active low
  input  wire logic [7:0] line_data_i,  // Frame byte
  input  wire logic       line_valid_i, // Byte valid
  input  wire logic       line_sof_i,   // First byte
  input  wire logic       line_fill_i,  // Fill marker
  output logic            line_ready_o  // Byte taken
);
  logic [7:0] byte_q [FRAME_BYTES];
  logic       fill_q [FRAME_BYTES];
  logic       sof_q  [FRAME_BYTES];
  int         count;
  int         tick;
  // Ready low two cycles in five; bytes kept opaque, no resync
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      line_ready_o <= 1'b0;
      count <= 0;
      tick <= 0;
    end else begin
      tick <= (tick + 1) % 5;
      line_ready_o <= (tick < 3);
      if (line_valid_i && line_ready_o && count < FRAME_BYTES) begin
        byte_q[count] <= line_data_i;
        fill_q[count] <= line_fill_i;
        sof_q[count] <= line_sof_i;
        count <= count + 1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb/ecfm_frame_mapper_tb.sv
// Self-checking bench for the core frame mapper
`timescale 1ns/1ps
`default_nettype none
module ecfm_frame_mapper_tb;
  import ecfm_pkg::*;
  typedef struct packed {
    logic [2:0] act; logic [2:0] id; logic loss; logic loop; logic [7:0] ctrl; logic oper;
  } ecfm_row_type;
  logic                  clk_i, rst_b_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic [7:0]            avs_address_i, app_data_i, line_data_o;
  logic [31:0]           avs_writedata_i, avs_readdata_o, rd;
  logic                  app_valid_i, app_ready_o, line_valid_o, line_sof_o, line_fill_o;
  logic                  line_ready_i, line_loss_i, loopback_req_i, loopback_o;
  logic                  section_oper_o, line_loss_ind_o, active_ind_o, w;
  logic [SPARE_BITS-1:0] spare_overhead_bits_o;
  logic [NUM_PAIRS-1:0]  pair_active_i, pair_id_ok_i;
  ecfm_row_type          rows [7];
  int                    n_mismatch, comparisons, i, j, p;
  ecfm_frame_mapper u_ecfm_frame_mapper (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hf),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .app_data_i(app_data_i), .app_valid_i(app_valid_i), .app_ready_o(app_ready_o),
    .line_data_o(line_data_o), .line_valid_o(line_valid_o), .line_sof_o(line_sof_o),
    .line_fill_o(line_fill_o), .spare_overhead_bits_o(spare_overhead_bits_o),
    .line_ready_i(line_ready_i), .pair_active_i(pair_active_i), .pair_id_ok_i(pair_id_ok_i),
    .line_loss_i(line_loss_i), .loopback_req_i(loopback_req_i), .loopback_o(loopback_o),
    .section_oper_o(section_oper_o), .line_loss_ind_o(line_loss_ind_o),
    .active_ind_o(active_ind_o));
  ecfm_line_model u_ecfm_line_model (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .line_data_i(line_data_o), .line_valid_i(line_valid_o), .line_sof_i(line_sof_o),
    .line_fill_i(line_fill_o), .line_ready_o(line_ready_i));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic give_up();
    n_mismatch++;
    $display("unexpected at %0t: got %h expected %h", $time, 1'b0, 1'b1);
    complete_run();
  endtask
  // Held until the edge where waitrequest is low
  task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    avs_address_i <= addr;
    avs_writedata_i <= wd;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    for (int k = 0; k < 50; k++) begin
      @(negedge clk_i);
      w = avs_waitrequest_o;
      rd = avs_readdata_o;
      @(posedge clk_i);
      if (!w) break;
    end
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    if (w) give_up();
    @(posedge clk_i);
  endtask
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  initial begin
    {rst_b_i, avs_read_i, avs_write_i, app_valid_i, line_loss_i, loopback_req_i} = '0;
    {avs_address_i, avs_writedata_i, app_data_i, pair_active_i, pair_id_ok_i} = '0;
    n_mismatch = 0;
    comparisons = 0;
    rows[0] = '{3'h7, 3'h7, 1'b0, 1'b0, 8'h00, 1'b1};
    rows[1] = '{3'h3, 3'h7, 1'b0, 1'b1, 8'h00, 1'b0};
    rows[2] = '{3'h7, 3'h5, 1'b0, 1'b0, 8'h00, 1'b0};
    rows[3] = '{3'h7, 3'h7, 1'b1, 1'b0, 8'h00, 1'b0};
    rows[4] = '{3'h7, 3'h7, 1'b0, 1'b0, 8'h04, 1'b0};
    rows[5] = '{3'h7, 3'h7, 1'b0, 1'b1, 8'h00, 1'b1};
    rows[6] = '{3'h7, 3'h7, 1'b0, 1'b0, 8'h02, 1'b1};
    repeat (4) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    bus(1'b0, REG_STATUS, 32'h0);
    check(rd, 32'h0);
    check({31'h0, &spare_overhead_bits_o}, 32'h1);
    $display("test reset done");
    for (i = 0; i < 7; i++) begin
      bus(1'b1, REG_CTRL, {24'h0, rows[i].ctrl});
      {pair_active_i, pair_id_ok_i, line_loss_i, loopback_req_i} <=
        {rows[i].act, rows[i].id, rows[i].loss, rows[i].loop};
      repeat (5) @(posedge clk_i);
      @(negedge clk_i);
      check({31'h0, section_oper_o}, {31'h0, rows[i].oper});
      check({31'h0, active_ind_o}, {31'h0, rows[i].oper});
      check({31'h0, line_loss_ind_o}, {31'h0, rows[i].loss});
      check({31'h0, loopback_o}, {31'h0, rows[i].loop});
      @(posedge clk_i);
      bus(1'b0, REG_STATUS, 32'h0);
      check({31'h0, rd[1]}, {31'h0, rows[i].oper});
      check({31'h0, rd[0]}, {31'h0, rows[i].ctrl[CTRL_UNSTRUCT]});
    end
    $display("test status rows done");
    bus(1'b1, REG_CTRL, 32'h1);
    fork
      begin
        for (j = 0; j < PAYLOAD_BYTES; j++) begin
          app_valid_i <= 1'b1;
          app_data_i <= 8'(j) ^ 8'ha5;
          for (int k = 0; k < 1000; k++) begin
            @(negedge clk_i);
            w = app_ready_o;
            @(posedge clk_i);
            if (w) break;
          end
          if (!w) give_up();
        end
        app_valid_i <= 1'b0;
      end
      for (int k = 0; k < 80000 && u_ecfm_line_model.count < FRAME_BYTES; k++) begin
        @(posedge clk_i);
      end
    join
    if (u_ecfm_line_model.count < FRAME_BYTES) give_up();
    p = 0;
    for (i = 0; i < FRAME_BYTES; i++) begin
      w = (i % FILL_PERIOD == FILL_PERIOD - 1);
      check({31'h0, u_ecfm_line_model.fill_q[i]}, {31'h0, w});
      check({31'h0, u_ecfm_line_model.sof_q[i]}, {31'h0, i == 0});
      check({24'h0, u_ecfm_line_model.byte_q[i]}, {24'h0, w ? 8'hff : 8'(p) ^ 8'ha5});
      if (!w) p++;
    end
    check(p, PAYLOAD_BYTES);
    bus(1'b0, REG_FRAMES, 32'h0);
    check(rd, 32'h1);
    $display("test frame done");
    bus(1'b1, 8'h10, 32'h0);
    bus(1'b0, 8'h10, 32'h0);
    check(rd, BAD_ADDR_DATA);
    bus(1'b0, REG_CTRL, 32'h0);
    check(rd, 32'h1);
    $display("test unmapped done");
    rst_b_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    check({30'h0, app_ready_o, section_oper_o}, 32'h2);
    @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    bus(1'b0, REG_CTRL, 32'h0);
    check(rd, 32'h0);
    $display("test second reset done");
    complete_run();
  end
endmodule
bind ecfm_frame_mapper ecfm_frame_mapper_chk u_ecfm_frame_mapper_chk (.clk_i(clk_i),
  .rst_b_i(rst_b_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_waitrequest_o(avs_waitrequest_o), .line_data_o(line_data_o),
  .line_valid_o(line_valid_o), .line_sof_o(line_sof_o), .line_fill_o(line_fill_o),
  .spare_overhead_bits_o(spare_overhead_bits_o), .line_ready_i(line_ready_i),
  .pair_active_i(pair_active_i), .line_loss_i(line_loss_i),
  .loopback_req_i(loopback_req_i), .loopback_o(loopback_o),
  .section_oper_o(section_oper_o), .line_loss_ind_o(line_loss_ind_o),
  .active_ind_o(active_ind_o));
`default_nettype wire
